// [rtl/polc_ctrl.sv]
// Output on/off, margin and setpoint command layer of a regulator bus slave.
// Assumes a link-side byte engine hands whole commands on link_clk, waits for
// rx_valid before the next, and that the host paces store/restore commands.
// Operation
// [RULE_01] On/off field: 00 off at once, 01 ramped off, 10 on.
// [RULE_02] On/off field acted on only when bus enabling is configured.
// [RULE_03] Margin field: 00 nominal, 01 margin low, 10 margin high.
// [RULE_04] Fault field: 01 ignore voltage faults while margined, 10 act.
// [RULE_05] Power-up bit set keeps output off until pin or bus turns on.
// [RULE_06] Bus-enable bit: 0 ignore on/off field, 1 bus must command on.
// [RULE_07] Pin-enable bit: 0 ignore pin, 1 output only while pin asserted.
// [RULE_08] Pin polarity bit: 0 low enables, 1 high enables.
// [RULE_09] Pin turn-off style: 0 ramped, 1 fastest stop.
// [RULE_10] Clear-faults command clears every fault status bit.
// [RULE_11] Store-default saves configuration to default store; locked by default.
// [RULE_12] Restore-default reloads whole configuration from default store.
// [RULE_13] Store-user saves settings changed since last restore.
// [RULE_14] Host waits 20 ms after user store or restore.
// [RULE_15] User restore runs at power-up, overriding default values; reset empties the user store here, so the boot restore overrides nothing.
// [RULE_16] User restore sets security level one.
// [RULE_17] Format byte holds five-bit signed exponent in bits 4:0.
// [RULE_18] Format bits 7:5: 000 linear, 001 VID, 010 direct.
// [RULE_19] Nominal setpoint is a 16-bit unsigned word.
// [RULE_20] Trim is signed, added to setpoint, limited to 150 mV.
// [RULE_21] Calibration offset is signed and acts like trim.
// [RULE_22] Margin states use margin-high and margin-low targets.
// [RULE_23] Both sources selected need both on; unlisted codes change nothing.
`timescale 1ns/10ps
`include "polc_defs.svh"

module polc_ctrl
    import polc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               link_clk,
    input  wire logic               tx_valid,
    input  wire polc_cmd_type       tx_cmd,
    output logic                    tx_ready,
    output logic                    rx_valid,
    output polc_resp_type           rx_resp,
    input  wire logic               ctrl_pin,
    input  wire logic               nvm_unlock,
    input  wire logic [7:0]         fault_event,
    output logic                    out_enable,
    output logic                    off_immediate,
    output logic                    ovuv_ignore,
    output logic [15:0]             vout_target,
    output logic [7:0]              fault_status,
    output logic [1:0]              security_level
);

    typedef struct packed {
        logic          req_tgl;
        logic          ack_s1;
        logic          ack_s2;
        logic          ack_prev;
        logic          busy;
        polc_cmd_type  cmd;
        logic          rx_valid;
        polc_resp_type resp;
    } polc_link_state_type;

    typedef struct packed {
        logic            req_s1;
        logic            req_s2;
        logic            req_prev;
        logic            ack_tgl;
        logic            ctrl_s1;
        logic            ctrl_s2;
        logic [6:0][15:0] cfgw;
        logic [6:0][15:0] dflt;
        logic [6:0][15:0] user;
        logic [6:0]      dirty;
        logic [6:0]      user_ok;
        logic            boot;
        logic            bus_on;
        logic            bus_fast;
        logic            ign_faults;
        logic            out_en;
        logic            off_fast;
        polc_margin_type margin;
        logic [1:0]      sec;
        logic [7:0]      faults;
        polc_resp_type   resp;
        logic [15:0]     target;
    } polc_core_state_type;

    polc_link_state_type l;
    polc_link_state_type next_l;
    polc_core_state_type c;
    polc_core_state_type next_c;

    logic               exec;
    logic               hit;
    logic [2:0]         idx;
    logic               pin_ok;
    logic               run;
    logic               cfg_pup;
    logic               cfg_bus;
    logic               cfg_pin;
    logic [15:0]        base;
    logic [15:0]        trim_eff;
    logic [17:0]        sum;
    logic [15:0]        wval;

    // Link side: holds one command until the core answers
    always_comb begin
        next_l          = l;
        next_l.ack_s1   = c.ack_tgl;
        next_l.ack_s2   = l.ack_s1;
        next_l.rx_valid = 1'b0;
        if (!l.busy && tx_valid) begin
            next_l.cmd     = tx_cmd;
            next_l.req_tgl = ~l.req_tgl;
            next_l.busy    = 1'b1;
        end else if (l.busy && (l.ack_s2 != l.ack_prev)) begin
            // Core answer is stable until the next request toggle
            next_l.ack_prev = l.ack_s2;
            next_l.busy     = 1'b0;
            next_l.rx_valid = 1'b1;
            next_l.resp     = c.resp;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign tx_ready = ~l.busy;
    assign rx_valid = l.rx_valid;
    assign rx_resp  = l.resp;

    assign exec    = (c.req_s2 != c.req_prev) && !c.boot;
    assign cfg_pup = c.cfgw[`POLC_IDX_CFG][`POLC_CFG_POWERUP];
    assign cfg_bus = c.cfgw[`POLC_IDX_CFG][`POLC_CFG_BUS_EN];
    assign cfg_pin = c.cfgw[`POLC_IDX_CFG][`POLC_CFG_PIN_EN];

    // [RULE_08] pin polarity select
    assign pin_ok = c.cfgw[`POLC_IDX_CFG][`POLC_CFG_PIN_POL] ? c.ctrl_s2 : ~c.ctrl_s2;

    // [RULE_05] power-up gating
    // [RULE_06] bus source role
    // [RULE_07] pin source role
    // [RULE_23] both sources combined
    assign run = ~cfg_pup | ((~cfg_pin | pin_ok) & (~cfg_bus | c.bus_on) & (cfg_pin | cfg_bus));

    // [RULE_22] margin target select
    // [RULE_03] nominal when not margined
    always_comb begin
        unique case (c.margin)
            POLC_MHIGH: base = c.cfgw[`POLC_IDX_MHI];
            POLC_MLOW:  base = c.cfgw[`POLC_IDX_MLO];
            default:    base = c.cfgw[`POLC_IDX_NOM];
        endcase
    end

    // [RULE_20] trim limited to range
    always_comb begin
        trim_eff = c.cfgw[`POLC_IDX_TRIM];
        if ($signed(trim_eff) > $signed(`POLC_TRIM_LIMIT)) begin
            trim_eff = `POLC_TRIM_LIMIT;
        end else if ($signed(trim_eff) < -$signed(`POLC_TRIM_LIMIT)) begin
            trim_eff = 16'(-$signed(`POLC_TRIM_LIMIT));
        end
    end

    // [RULE_21] calibration adds like trim
    assign sum = {2'b00, base} + {{2{trim_eff[15]}}, trim_eff}
               + {{2{c.cfgw[`POLC_IDX_CAL][15]}}, c.cfgw[`POLC_IDX_CAL]};

    always_comb begin
        hit = 1'b1;
        idx = `POLC_IDX_OP;
        unique case (l.cmd.code)
            `POLC_CMD_OPERATION:    idx = `POLC_IDX_OP;
            `POLC_CMD_ON_OFF_CFG:   idx = `POLC_IDX_CFG;
            // [RULE_19] nominal setpoint word
            `POLC_CMD_VOUT_NOMINAL: idx = `POLC_IDX_NOM;
            `POLC_CMD_VOUT_TRIM:    idx = `POLC_IDX_TRIM;
            `POLC_CMD_VOUT_CAL:     idx = `POLC_IDX_CAL;
            `POLC_CMD_MARGIN_HIGH:  idx = `POLC_IDX_MHI;
            `POLC_CMD_MARGIN_LOW:   idx = `POLC_IDX_MLO;
            default:                hit = 1'b0;
        endcase
    end

    // Byte-wide commands keep their upper byte at zero
    assign wval = (idx == `POLC_IDX_OP || idx == `POLC_IDX_CFG) ?
                  (l.cmd.data & 16'h00ff) : l.cmd.data;

    always_comb begin
        next_c         = c;
        next_c.req_s1  = l.req_tgl;
        next_c.req_s2  = c.req_s1;
        next_c.req_prev = c.req_s2;
        next_c.ctrl_s1 = ctrl_pin;
        next_c.ctrl_s2 = c.ctrl_s1;
        if (c.boot) begin
            // [RULE_15] power-up user restore
            next_c.boot = 1'b0;
            for (int i = 0; i < 7; i++) begin
                if (c.user_ok[i]) begin
                    next_c.cfgw[i] = c.user[i];
                end
            end
            next_c.dirty = '0;
            next_c.sec   = `POLC_SEC_LEVEL1;
        end else if (exec) begin
            next_c.ack_tgl   = ~c.ack_tgl;
            next_c.resp.ack  = 1'b1;
            next_c.resp.data = 16'h0000;
            if (hit) begin
                if (l.cmd.write) begin
                    next_c.cfgw[idx]  = wval;
                    next_c.dirty[idx] = 1'b1;
                end else begin
                    next_c.resp.data = c.cfgw[idx];
                end
            end else begin
                unique case (l.cmd.code)
                    `POLC_CMD_CLEAR_FAULTS: begin
                        next_c.resp.ack = l.cmd.write;
                    end
                    `POLC_CMD_STORE_DFLT: begin
                        // [RULE_11] locked unless unlocked
                        next_c.resp.ack = l.cmd.write & nvm_unlock;
                        if (l.cmd.write && nvm_unlock) begin
                            next_c.dflt = c.cfgw;
                        end
                    end
                    `POLC_CMD_RESTORE_DFLT: begin
                        // [RULE_12] reload default store
                        next_c.resp.ack = l.cmd.write;
                        if (l.cmd.write) begin
                            next_c.cfgw  = c.dflt;
                            next_c.dirty = '0;
                        end
                    end
                    `POLC_CMD_STORE_USER: begin
                        // [RULE_13] save changed words only
                        next_c.resp.ack = l.cmd.write;
                        for (int i = 0; i < 7; i++) begin
                            if (l.cmd.write && c.dirty[i]) begin
                                next_c.user[i]    = c.cfgw[i];
                                next_c.user_ok[i] = 1'b1;
                            end
                        end
                    end
                    `POLC_CMD_RESTORE_USER: begin
                        // [RULE_16] restore then level one
                        next_c.resp.ack = l.cmd.write;
                        if (l.cmd.write) begin
                            for (int i = 0; i < 7; i++) begin
                                if (c.user_ok[i]) begin
                                    next_c.cfgw[i] = c.user[i];
                                end
                            end
                            next_c.dirty = '0;
                            next_c.sec   = `POLC_SEC_LEVEL1;
                        end
                    end
                    `POLC_CMD_VOUT_FORMAT: begin
                        // [RULE_17] exponent in low bits
                        // [RULE_18] mode in top bits
                        next_c.resp.ack  = ~l.cmd.write;
                        next_c.resp.data = {8'h00, `POLC_VOUT_FORMAT};
                    end
                    default: begin
                        next_c.resp.ack = 1'b0;
                    end
                endcase
            end
            if (hit && l.cmd.write && idx == `POLC_IDX_OP) begin
                // [RULE_02] on/off only with bus enabling
                // [RULE_01] on/off field decode
                if (cfg_bus) begin
                    unique case (wval[`POLC_OP_ONOFF_HI:`POLC_OP_ONOFF_LO])
                        2'b00: begin
                            next_c.bus_on   = 1'b0;
                            next_c.bus_fast = 1'b1;
                        end
                        2'b01: begin
                            next_c.bus_on   = 1'b0;
                            next_c.bus_fast = 1'b0;
                        end
                        2'b10:   next_c.bus_on = 1'b1;
                        default: next_c.bus_on = c.bus_on;
                    endcase
                end
                // [RULE_03] margin field decode
                unique case (wval[`POLC_OP_MARGIN_HI:`POLC_OP_MARGIN_LO])
                    2'b00:   next_c.margin = POLC_NOMINAL;
                    2'b01:   next_c.margin = POLC_MLOW;
                    2'b10:   next_c.margin = POLC_MHIGH;
                    default: next_c.margin = c.margin;
                endcase
                // [RULE_04] fault handling field
                unique case (wval[`POLC_OP_FAULT_HI:`POLC_OP_FAULT_LO])
                    2'b01:   next_c.ign_faults = 1'b1;
                    2'b10:   next_c.ign_faults = 1'b0;
                    default: next_c.ign_faults = c.ign_faults;
                endcase
            end
        end
        // [RULE_10] clear faults, new event wins
        next_c.faults = ((exec && l.cmd.code == `POLC_CMD_CLEAR_FAULTS && l.cmd.write) ?
                        8'h00 : c.faults) | fault_event;
        next_c.out_en = run;
        // [RULE_09] pin turn-off style
        if (c.out_en && !run) begin
            next_c.off_fast = (cfg_pin && !pin_ok) ?
                              c.cfgw[`POLC_IDX_CFG][`POLC_CFG_PIN_FAST] : c.bus_fast;
        end else if (run) begin
            next_c.off_fast = 1'b0;
        end
        if (sum[17]) begin
            next_c.target = 16'h0000;
        end else if (sum[16]) begin
            next_c.target = 16'hffff;
        end else begin
            next_c.target = sum[15:0];
        end
    end

    // User store clears and default store reloads reset values on reset; a limitation of this volatile emulation
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            c      <= '0;
            c.boot <= 1'b1;
            c.cfgw <= {`POLC_RST_MLO, `POLC_RST_MHI, `POLC_RST_CAL, `POLC_RST_TRIM,
                       `POLC_RST_NOM, `POLC_RST_CFG, `POLC_RST_OP};
            c.dflt <= {`POLC_RST_MLO, `POLC_RST_MHI, `POLC_RST_CAL, `POLC_RST_TRIM,
                       `POLC_RST_NOM, `POLC_RST_CFG, `POLC_RST_OP};
        end else begin
            c <= next_c;
        end
    end

    assign out_enable     = c.out_en;
    assign off_immediate  = c.off_fast;
    // [RULE_04] ignore only while margined
    assign ovuv_ignore    = c.ign_faults & (c.margin != POLC_NOMINAL);
    assign vout_target    = c.target;
    assign fault_status   = c.faults;
    assign security_level = c.sec;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_pup_stays_off: assert property (cfg_pup && !cfg_pin && !cfg_bus |=> !out_enable) // [RULE_05]
        else $error("output on with no enable source");
    chk_pin_gates_out: assert property (cfg_pup && cfg_pin && !pin_ok |=> !out_enable) // [RULE_07]
        else $error("output on while pin deasserted");
    chk_bus_ignored: assert property (exec && hit && l.cmd.write && idx == `POLC_IDX_OP
        && !cfg_bus |=> $stable(c.bus_on)) // [RULE_02]
        else $error("on/off field acted on without bus enabling");
    chk_bus_turn_on: assert property (exec && hit && l.cmd.write && idx == `POLC_IDX_OP
        && cfg_bus && wval[7:6] == 2'b10 |=> c.bus_on ##1 (out_enable || cfg_pin || !cfg_pup)) // [RULE_01]
        else $error("bus on command not followed by enable");
    chk_margin_keep: assert property (exec && hit && l.cmd.write && idx == `POLC_IDX_OP
        && wval[5:4] == 2'b11 |=> $stable(c.margin)) // [RULE_23]
        else $error("unlisted margin code changed state");
    chk_margin_high: assert property (c.margin == POLC_MHIGH && c.cfgw[3] == 16'h0000
        && c.cfgw[4] == 16'h0000 |=> vout_target == $past(c.cfgw[5])) // [RULE_22]
        else $error("margin high target wrong");
    chk_clear_faults: assert property (exec && l.cmd.code == `POLC_CMD_CLEAR_FAULTS
        && l.cmd.write |=> fault_status == $past(fault_event)) // [RULE_10]
        else $error("faults not cleared");
    chk_store_user: assert property (exec && l.cmd.code == `POLC_CMD_STORE_USER
        && l.cmd.write && c.dirty[2] |=> c.user[2] == $past(c.cfgw[2])) // [RULE_13]
        else $error("changed setpoint not stored");
    chk_restore_user: assert property (c.boot || (exec && l.cmd.code == `POLC_CMD_RESTORE_USER
        && l.cmd.write) |=> security_level == `POLC_SEC_LEVEL1 && c.dirty == 7'h00) // [RULE_16]
        else $error("user restore did not set level one");
    chk_restore_dflt: assert property (exec && l.cmd.code == `POLC_CMD_RESTORE_DFLT
        && l.cmd.write |=> c.cfgw == $past(c.dflt)) // [RULE_12]
        else $error("default restore incomplete");
    chk_dflt_locked: assert property (exec && l.cmd.code == `POLC_CMD_STORE_DFLT
        && !nvm_unlock |=> $stable(c.dflt)) // [RULE_11]
        else $error("locked default store changed");
    chk_format_read: assert property (exec && l.cmd.code == `POLC_CMD_VOUT_FORMAT
        && !l.cmd.write |=> c.resp.data == 16'h0014) // [RULE_17]
        else $error("format byte wrong");

    cov_bus_on: cover property (exec && idx == `POLC_IDX_OP && cfg_bus ##[1:4] out_enable);
    cov_pin_off: cover property (out_enable ##1 !out_enable && off_immediate);
    cov_store_restore: cover property (exec && l.cmd.code == `POLC_CMD_STORE_USER
        ##[1:200] exec && l.cmd.code == `POLC_CMD_RESTORE_USER);

endmodule

// [include/polc_defs.svh]
// Constants of the output control command layer: codes, indices, resets.
// Assumes a single includer per compilation unit; guarded anyway.
`ifndef POLC_DEFS_SVH
`define POLC_DEFS_SVH

// Command codes
`define POLC_CMD_OPERATION     8'h01
`define POLC_CMD_ON_OFF_CFG    8'h02
`define POLC_CMD_CLEAR_FAULTS  8'h03
`define POLC_CMD_STORE_DFLT    8'h11
`define POLC_CMD_RESTORE_DFLT  8'h12
`define POLC_CMD_STORE_USER    8'h15
`define POLC_CMD_RESTORE_USER  8'h16
`define POLC_CMD_VOUT_FORMAT   8'h20
`define POLC_CMD_VOUT_NOMINAL  8'h21
`define POLC_CMD_VOUT_TRIM     8'h22
`define POLC_CMD_VOUT_CAL      8'h23
`define POLC_CMD_MARGIN_HIGH   8'h25
`define POLC_CMD_MARGIN_LOW    8'h26

// Configuration word indices
`define POLC_IDX_OP            3'h0
`define POLC_IDX_CFG           3'h1
`define POLC_IDX_NOM           3'h2
`define POLC_IDX_TRIM          3'h3
`define POLC_IDX_CAL           3'h4
`define POLC_IDX_MHI           3'h5
`define POLC_IDX_MLO           3'h6

// Field positions
`define POLC_OP_ONOFF_HI       7
`define POLC_OP_ONOFF_LO       6
`define POLC_OP_MARGIN_HI      5
`define POLC_OP_MARGIN_LO      4
`define POLC_OP_FAULT_HI       3
`define POLC_OP_FAULT_LO       2
`define POLC_CFG_POWERUP       4
`define POLC_CFG_BUS_EN        3
`define POLC_CFG_PIN_EN        2
`define POLC_CFG_PIN_POL       1
`define POLC_CFG_PIN_FAST      0

// Reset and factory values
`define POLC_RST_OP            16'h0000
`define POLC_RST_CFG           16'h0016
`define POLC_RST_NOM           16'h0ccd
`define POLC_RST_TRIM          16'h0000
`define POLC_RST_CAL           16'h0000
`define POLC_RST_MHI           16'h0d9a
`define POLC_RST_MLO           16'h0c00
// Linear format, exponent -12
`define POLC_VOUT_FORMAT       8'h14
// 150 mV at 2^-12 V per count
`define POLC_TRIM_LIMIT        16'h0266
`define POLC_SEC_LEVEL1        2'h1

`endif

// [include/polc_pkg.sv]
// Types of the output control command layer.
// Assumes polc_defs.svh supplies all numeric constants.
package polc_pkg;

    typedef enum logic [1:0] {
        POLC_NOMINAL = 2'b00,
        POLC_MLOW    = 2'b01,
        POLC_MHIGH   = 2'b10
    } polc_margin_type;

    typedef struct packed {
        logic [7:0]  code;
        logic        write;
        logic [15:0] data;
    } polc_cmd_type;

    typedef struct packed {
        logic        ack;
        logic [15:0] data;
    } polc_resp_type;

endpackage

// [verif/polc_host.sv]
// Host model: one command at a time on the link port.
// Assumes link_clk runs, ready comes within 40 cycles and every answer within 80 cycles.
`timescale 1ns/10ps
module polc_host
    import polc_pkg::*;
(
    input  wire logic          link_clk,
    input  wire logic          tx_ready,
    input  wire logic          rx_valid,
    input  wire polc_resp_type rx_resp,
    output logic               tx_valid,
    output polc_cmd_type       tx_cmd,
    output logic               timed_out
);
    localparam realtime GAP = 20000000.0;
    realtime            last_user = -GAP;
    initial begin
        tx_valid = 1'b0;
        tx_cmd = '0;
        timed_out = 1'b0;
    end
    task automatic send(input logic [7:0] c, input logic w, input logic [15:0] d,
                        output polc_resp_type resp);
        int n;
        if ($realtime < last_user + GAP) #(last_user + GAP - $realtime);
        @(negedge link_clk);
        tx_cmd = '{code: c, write: w, data: d};
        tx_valid = 1'b1;
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 40);
        @(negedge link_clk);
        tx_valid = 1'b0;
        // Released lines never show the last value
        tx_cmd = ~tx_cmd;
        do begin
            @(posedge link_clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 80);
        resp = rx_resp;
        timed_out = (n >= 80);
        if (c == 8'h15 || c == 8'h16) last_user = $realtime;
    endtask
endmodule

// [verif/tb_top.sv]
// Self-checking bench of the output control command layer.
// Assumes the link answers in a few cycles; pin and faults on clk.
`timescale 1ns/10ps
`include "polc_defs.svh"
module tb_top;
    import polc_pkg::*;
    logic          clk = 0, link_clk = 0, arst_n = 0, ctrl_pin = 1, nvm_unlock = 0;
    logic          tx_valid, tx_ready, rx_valid, timed_out, out_enable, off_immediate;
    logic          ovuv_ignore, bus_on = 0, bus_soft = 1, pin_ok, bus_ok, on;
    logic          was_on = 1, fast_exp = 0;
    polc_cmd_type  tx_cmd;
    polc_resp_type rx_resp, r;
    logic [7:0]    fault_event = 0, fault_status, fv, c;
    logic [15:0]   vout_target, v [5];
    logic [7:0]    codes [5] = '{8'h21, 8'h22, 8'h23, 8'h25, 8'h26};
    logic [7:0]    cfgs [7] = '{8'h16, 8'h17, 8'h14, 8'h18, 8'h1c, 8'h06, 8'h10};
    logic [1:0]    security_level, margin = 0;
    int            err_count = 0, checks_done = 0, cycles = 0, seed = 26;

    polc_ctrl uut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .tx_valid(tx_valid),
        .tx_cmd(tx_cmd), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_resp(rx_resp),
        .ctrl_pin(ctrl_pin), .nvm_unlock(nvm_unlock), .fault_event(fault_event),
        .out_enable(out_enable), .off_immediate(off_immediate), .ovuv_ignore(ovuv_ignore),
        .vout_target(vout_target), .fault_status(fault_status),
        .security_level(security_level));
    polc_host host (.link_clk(link_clk), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_resp(rx_resp), .tx_valid(tx_valid), .tx_cmd(tx_cmd), .timed_out(timed_out));

    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Ceiling well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] k, input logic w, input logic [15:0] d,
                       input logic a);
        host.send(k, w, d, r);
        if (timed_out) begin
            err_count++;
            report_and_stop();
        end
        check(r.ack, a);
        repeat (4) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] k, input logic [15:0] e);
        cmd(k, 1'b0, 16'h0000, 1'b1);
        check(r.data, e);
    endtask
    // Base by margin state, trim clamped, calibration added, saturated
    function automatic logic [15:0] exp_target();
        logic signed [17:0] t, s, lim;
        lim = {2'b00, `POLC_TRIM_LIMIT};
        t = {{2{v[1][15]}}, v[1]};
        if (t > lim) t = lim;
        if (t < -lim) t = -lim;
        s = {2'b00, margin == 2 ? v[3] : margin == 1 ? v[4] : v[0]};
        s = s + t + {{2{v[2][15]}}, v[2]};
        if (s < 0) return 16'h0000;
        return s > 18'sh0ffff ? 16'hffff : s[15:0];
    endfunction
    // Turn-off style is latched only at the step that turns the output off
    function automatic void track();
        pin_ok = !c[2] || (ctrl_pin == c[1]);
        bus_ok = !c[3] || bus_on;
        on = !c[4] || ((c[3] || c[2]) && pin_ok && bus_ok);
        if (was_on && !on) fast_exp = (c[2] && !pin_ok) ? c[0] : !bus_soft;
        if (on) fast_exp = 1'b0;
        was_on = on;
    endfunction

    initial begin
        v = '{`POLC_RST_NOM, `POLC_RST_TRIM, `POLC_RST_CAL, `POLC_RST_MHI, `POLC_RST_MLO};
        repeat (10) @(negedge clk);
        check(tx_ready, 1'b1);
        repeat (10) @(negedge clk);
        arst_n = 1;
        repeat (5) @(negedge clk);
        check(security_level, `POLC_SEC_LEVEL1);
        check(out_enable, 1'b1);
        rd(8'h02, `POLC_RST_CFG);
        for (int k = 0; k < 5; k++) rd(codes[k], v[k]);
        rd(8'h20, {8'h00, `POLC_VOUT_FORMAT});
        cmd(8'h20, 1'b1, 16'h0055, 1'b0);
        cmd(8'h7e, 1'b0, 16'h0000, 1'b0);
        cmd(8'h03, 1'b0, 16'h0000, 1'b0);
        $display("test reset and refusals done");
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 5; k++) v[k] = 16'($random(seed));
            if (i < 2) v[1] = i ? 16'hfd99 : 16'h0267;
            for (int k = 0; k < 5; k++) cmd(codes[k], 1'b1, v[k], 1'b1);
            for (int k = 0; k < 5; k++) rd(codes[k], v[k]);
            check(vout_target, exp_target());
        end
        for (int m = 0; m < 3; m++) begin
            for (int f = 1; f < 3; f++) begin
                margin = 2'(m);
                cmd(8'h01, 1'b1, {8'h00, 2'b11, margin, f[1:0], 2'b00}, 1'b1);
                check(vout_target, exp_target());
                check(ovuv_ignore, m != 0 && f == 1);
            end
        end
        cmd(8'h01, 1'b1, 16'h00fc, 1'b1);
        check(vout_target, exp_target());
        $display("test setpoint and margin done");
        for (int i = 0; i < 42; i++) begin
            c = cfgs[i / 6];
            margin = 2'b00;
            cmd(8'h02, 1'b1, {8'h00, c}, 1'b1);
            track();
            cmd(8'h01, 1'b1, {8'h00, 2'(i % 3), 6'h00}, 1'b1);
            if (c[3]) bus_on = (i % 3 == 2);
            // On command leaves the bus turn-off style as it was
            if (c[3] && i % 3 != 2) bus_soft = (i % 3 == 1);
            track();
            ctrl_pin = 1'((i / 3) % 2);
            repeat (5) @(negedge clk);
            track();
            check(out_enable, on);
            check(off_immediate, fast_exp);
        end
        $display("test enable sources done");
        fv = 8'($random(seed)) | 8'h01;
        fault_event = fv;
        @(negedge clk);
        fault_event = 0;
        repeat (2) @(negedge clk);
        check(fault_status, fv);
        cmd(8'h03, 1'b1, 16'h0000, 1'b1);
        check(fault_status, 8'h00);
        cmd(8'h11, 1'b1, 16'h0000, 1'b0);
        cmd(8'h21, 1'b1, 16'h0a5a, 1'b1);
        nvm_unlock = 1;
        cmd(8'h11, 1'b1, 16'h0000, 1'b1);
        cmd(8'h21, 1'b1, 16'h05a5, 1'b1);
        cmd(8'h12, 1'b1, 16'h0000, 1'b1);
        rd(8'h21, 16'h0a5a);
        // A changed word gives the user store something to save
        cmd(8'h21, 1'b1, 16'h0bcd, 1'b1);
        cmd(8'h15, 1'b1, 16'h0000, 1'b1);
        $display("test faults and stores done");
        report_and_stop();
    end
endmodule
